// ==== design/ccdo_consts.svh ====
// Purpose: constants for the clear/call/decrement execution block
// Assumes: byte addresses on an 8-bit AXI4-Lite address
// Notes:   op codes and field positions belong to the command register
`ifndef CCDO_CONSTS_SVH
`define CCDO_CONSTS_SVH

// register byte addresses
`define CCDO_ADDR_INSTR   8'h00
`define CCDO_ADDR_STATUS  8'h04
`define CCDO_ADDR_WREG    8'h08
`define CCDO_ADDR_PCLATCH 8'h0C
`define CCDO_ADDR_PC      8'h10
`define CCDO_ADDR_TOS     8'h14
`define CCDO_ADDR_WDOG    8'h18
`define CCDO_ADDR_FADDR   8'h1C
`define CCDO_ADDR_FDATA   8'h20

// command word fields
`define CCDO_F_OP    3:0
`define CCDO_F_DEST  7
`define CCDO_F_FILE  14:8

// status bits
`define CCDO_ST_ZERO  0
`define CCDO_ST_PD    1
`define CCDO_ST_TO    2
`define CCDO_ST_BUSY  3
`define CCDO_ST_SKIP  4

// operation codes
`define CCDO_OP_NOP     4'h0
`define CCDO_OP_WDCLR   4'h1
`define CCDO_OP_CALL_VIA_WORKING_REG   4'h2
`define CCDO_OP_COMPLEMENT_FILE_INSTR    4'h3
`define CCDO_OP_CLEAR_FILE_INSTR    4'h4
`define CCDO_OP_DECREMENT_FILE_INSTR    4'h5
`define CCDO_OP_CLEAR_WORKING_INSTR    4'h6
`define CCDO_OP_DECSKZ  4'h7

// reset and clear values
`define CCDO_WDOG_CLEAR 8'h00
`define CCDO_BYTE_ZERO  8'h00
`define CCDO_FLAG_RESET 1'b1

// bus responses
`define CCDO_RESP_OKAY   2'h0
`define CCDO_RESP_SLVERR 2'h2

`endif

// ==== design/ccdo_pkg.sv ====
// Purpose: types shared by the execution block and its result unit
// Assumes: constants come from ccdo_consts.svh
// Notes:   all module state travels as one packed struct
package ccdo_pkg;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SECOND} ccdo_fsm_t;

  typedef struct packed {
    logic [3:0] op;
    logic       dest;
    logic [7:0] fval;
  } ccdo_alu_in_t;

  typedef struct packed {
    logic [7:0] res;
    logic       to_w;
    logic       to_f;
    logic       z_upd;
    logic       z_val;
    logic       skip;
  } ccdo_alu_out_t;

  typedef struct packed {
    ccdo_fsm_t         fsm;
    logic [15:0]       instr;
    logic [7:0]        w;
    logic [6:0]        pclatch;
    logic [14:0]       pc;
    logic [15:0][14:0] stack;
    logic [3:0]        sp;
    logic [127:0][7:0] file;
    logic [6:0]        faddr;
    logic              zero;
    logic              timeout_flag;
    logic              powerdown_flag;
    logic              skipped;
    logic [7:0]        wdog_cnt;
    logic [7:0]        wdog_pre;
    logic              aw_held;
    logic [7:0]        awaddr;
    logic              w_held;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } ccdo_regs_t;

endpackage : ccdo_pkg

// ==== design/ccdo_alu.sv ====
// Purpose: result, destination and flag decisions for one operation
// Assumes: purely combinational, used inside the execution cycle
// Notes:   operations outside this group yield no write and no flag change
`timescale 1ns/10ps
`include "ccdo_consts.svh"
module ccdo_alu (
  input  ccdo_pkg::ccdo_alu_in_t  alu_i,
  output ccdo_pkg::ccdo_alu_out_t alu_o
);
  import ccdo_pkg::*;

  // decode the operation into a result and its destination
  always_comb begin
    alu_o = '0;
    case (alu_i.op)
      `CCDO_OP_COMPLEMENT_FILE_INSTR: begin
        alu_o.res   = ~alu_i.fval;
        alu_o.to_w  = ~alu_i.dest;
        alu_o.to_f  = alu_i.dest;
        alu_o.z_upd = 1'b1;
      end
      `CCDO_OP_CLEAR_FILE_INSTR: begin
        alu_o.res   = `CCDO_BYTE_ZERO;
        alu_o.to_f  = 1'b1;
        alu_o.z_upd = 1'b1;
      end
      `CCDO_OP_DECREMENT_FILE_INSTR: begin
        alu_o.res   = alu_i.fval - 8'h01;
        alu_o.to_w  = ~alu_i.dest;
        alu_o.to_f  = alu_i.dest;
        alu_o.z_upd = 1'b1;
      end
      `CCDO_OP_CLEAR_WORKING_INSTR: begin
        alu_o.res   = `CCDO_BYTE_ZERO;
        alu_o.to_w  = 1'b1;
        alu_o.z_upd = 1'b1;
      end
      `CCDO_OP_DECSKZ: begin
        alu_o.res   = alu_i.fval - 8'h01;
        alu_o.to_w  = ~alu_i.dest;
        alu_o.to_f  = alu_i.dest;
        alu_o.skip  = (alu_i.fval == 8'h01);
      end
      default: begin
        alu_o.res = `CCDO_BYTE_ZERO;
      end
    endcase
    // zero flag follows the 8-bit result
    alu_o.z_val = (alu_o.res == `CCDO_BYTE_ZERO);
  end

endmodule : ccdo_alu

// ==== design/ccdo_core.sv ====
// Purpose: executes watchdog clear, call via W, complement, clear and
//          decrement operations issued through an AXI4-Lite command register
// Assumes: aclk at 100 MHz, synchronous active-low reset, ce freezes all
// Notes:   one clock is one instruction cycle; writes refused while busy
// How it works
// RULE1: watchdog clear zeroes counter and prescaler
// RULE2: watchdog clear sets timeout and powerdown flags
// RULE3: call via W pushes PC plus one
// RULE4: then PC gets upper latch and W
// RULE5: call via W: two cycles, no flags
// RULE6: complement file, dest bit picks target, zero
// RULE7: clear file writes zero, sets zero flag
// RULE8: decrement file, dest bit picks target, zero
// RULE9: clear W writes zero, sets zero flag
// RULE10: decrement-skip stores result, flags untouched
// RULE11: zero result skips next, two cycles
// RULE12: zero flag set exactly when result zero
`timescale 1ns/10ps
`include "ccdo_consts.svh"
module ccdo_core (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import ccdo_pkg::*;

  ccdo_regs_t    r_q;
  ccdo_regs_t    r_d;
  ccdo_alu_in_t  alu_i;
  ccdo_alu_out_t alu_o;
  logic [3:0]    op;
  logic          dest;
  logic [6:0]    fsel;
  logic [7:0]    fval;
  logic          exec;
  logic          busy;
  logic [31:0]   wr_old;
  logic [31:0]   wr_new;
  logic          rd_hit;
  logic          wr_hit;

  // read view of every register; hit reports a mapped address
  function automatic logic [31:0] rd_mux(input logic [7:0] a, input ccdo_regs_t r,
                                         output logic hit);
    logic [31:0] v;
    v   = 32'h0000_0000;
    hit = 1'b1;
    case (a)
      `CCDO_ADDR_INSTR:   v[15:0] = r.instr;
      `CCDO_ADDR_STATUS: begin
        v[`CCDO_ST_ZERO] = r.zero;
        v[`CCDO_ST_PD]   = r.powerdown_flag;
        v[`CCDO_ST_TO]   = r.timeout_flag;
        v[`CCDO_ST_BUSY] = (r.fsm != ST_IDLE);
        v[`CCDO_ST_SKIP] = r.skipped;
      end
      `CCDO_ADDR_WREG:    v[7:0]   = r.w;
      `CCDO_ADDR_PCLATCH: v[6:0]   = r.pclatch;
      `CCDO_ADDR_PC:      v[14:0]  = r.pc;
      `CCDO_ADDR_TOS:     v[19:0]  = {r.sp, 1'b0, r.stack[r.sp]};
      `CCDO_ADDR_WDOG:    v[15:0]  = {r.wdog_pre, r.wdog_cnt};
      `CCDO_ADDR_FADDR:   v[6:0]   = r.faddr;
      `CCDO_ADDR_FDATA:   v[7:0]   = r.file[r.faddr];
      default:            hit      = 1'b0;
    endcase
    return v;
  endfunction : rd_mux

  // merge written byte lanes over the current contents
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // operand fields of the command being executed
  assign op    = r_q.instr[`CCDO_F_OP];
  assign dest  = r_q.instr[`CCDO_F_DEST];
  assign fsel  = r_q.instr[`CCDO_F_FILE];
  assign fval  = r_q.file[fsel];
  assign exec  = (r_q.fsm == ST_EXEC);
  assign busy  = (r_q.fsm != ST_IDLE);
  assign alu_i = '{op: op, dest: dest, fval: fval};
  // held write: current word and merged lanes (output argument needs a process)
  always_comb begin
    wr_old = rd_mux(r_q.awaddr, r_q, wr_hit);
    wr_new = merge(wr_old, r_q.wdata, r_q.wstrb);
  end

  ccdo_alu u_alu (
    .alu_i (alu_i),
    .alu_o (alu_o)
  );

  // next state: watchdog, execution, then bus slave
  always_comb begin
    r_d    = r_q;
    rd_hit = 1'b0;
    // free-running watchdog; counter wrap drops the timeout flag (active low)
    r_d.wdog_pre = r_q.wdog_pre + 8'h01;
    if (r_q.wdog_pre == 8'hFF) begin
      r_d.wdog_cnt = r_q.wdog_cnt + 8'h01;
      if (r_q.wdog_cnt == 8'hFF) begin
        r_d.timeout_flag = 1'b0;
      end
    end
    // execution sequencer
    case (r_q.fsm)
      ST_EXEC: begin
        r_d.fsm     = ST_IDLE;
        r_d.pc      = r_q.pc + 15'h0001;
        r_d.skipped = 1'b0;
        if (alu_o.to_w) begin
          r_d.w = alu_o.res;                                  // [RULE6] [RULE8] [RULE9] [RULE10]
        end
        if (alu_o.to_f) begin
          r_d.file[fsel] = alu_o.res;                         // [RULE6] [RULE7] [RULE8] [RULE10]
        end
        if (alu_o.z_upd) begin
          r_d.zero = alu_o.z_val;                             // [RULE12]
        end
        if (op == `CCDO_OP_WDCLR) begin
          r_d.wdog_cnt       = `CCDO_WDOG_CLEAR;              // [RULE1]
          r_d.wdog_pre       = `CCDO_WDOG_CLEAR;              // [RULE1]
          r_d.timeout_flag   = 1'b1;                          // [RULE2]
          r_d.powerdown_flag = 1'b1;                          // [RULE2]
        end
        if (op == `CCDO_OP_CALL_VIA_WORKING_REG) begin
          r_d.sp              = r_q.sp + 4'h1;
          r_d.stack[r_d.sp]   = r_q.pc + 15'h0001;            // [RULE3]
          r_d.pc              = {r_q.pclatch, r_q.w};         // [RULE4]
          r_d.fsm             = ST_SECOND;                    // [RULE5]
        end
        if (alu_o.skip) begin
          r_d.pc      = r_q.pc + 15'h0002;                    // [RULE11]
          r_d.fsm     = ST_SECOND;                            // [RULE11]
          r_d.skipped = 1'b1;
        end
      end
      ST_SECOND: r_d.fsm = ST_IDLE;                           // no-op second cycle
      ST_IDLE:   r_d.fsm = ST_IDLE;
      default:   r_d.fsm = ST_IDLE;
    endcase
    // write address and data are taken independently
    if (s_axi_awvalid && r_q.awready) begin
      r_d.aw_held = 1'b1;
      r_d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_q.wready) begin
      r_d.w_held = 1'b1;
      r_d.wdata  = s_axi_wdata;
      r_d.wstrb  = s_axi_wstrb;
    end
    // perform a write once both halves are held
    if (r_q.aw_held && r_q.w_held && !r_q.bvalid) begin
      r_d.aw_held = 1'b0;
      r_d.w_held  = 1'b0;
      r_d.bvalid  = 1'b1;
      r_d.bresp   = `CCDO_RESP_OKAY;
      if (!wr_hit || busy) begin
        r_d.bresp = `CCDO_RESP_SLVERR;
      end else begin
        case (r_q.awaddr)
          `CCDO_ADDR_INSTR: begin
            r_d.instr = wr_new[15:0];
            r_d.fsm   = ST_EXEC;
          end
          `CCDO_ADDR_STATUS:  r_d.zero    = wr_new[`CCDO_ST_ZERO];
          `CCDO_ADDR_WREG:    r_d.w       = wr_new[7:0];
          `CCDO_ADDR_PCLATCH: r_d.pclatch = wr_new[6:0];
          `CCDO_ADDR_PC:      r_d.pc      = wr_new[14:0];
          `CCDO_ADDR_FADDR:   r_d.faddr   = wr_new[6:0];
          `CCDO_ADDR_FDATA:   r_d.file[r_q.faddr] = wr_new[7:0];
          default:            r_d.bresp   = `CCDO_RESP_OKAY;  // read-only, ignored
        endcase
      end
    end
    if (r_q.bvalid && s_axi_bready) begin
      r_d.bvalid = 1'b0;
    end
    r_d.awready = !r_d.aw_held && !r_d.bvalid;
    r_d.wready  = !r_d.w_held && !r_d.bvalid;
    // read channel: one outstanding read
    if (s_axi_arvalid && r_q.arready) begin
      r_d.rvalid = 1'b1;
      r_d.rdata  = rd_mux(s_axi_araddr, r_q, rd_hit);
      r_d.rresp  = rd_hit ? `CCDO_RESP_OKAY : `CCDO_RESP_SLVERR;
    end
    if (r_q.rvalid && s_axi_rready) begin
      r_d.rvalid = 1'b0;
    end
    r_d.arready = !r_d.rvalid;
  end

  // state register; ce low freezes everything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_q                <= '0;
      r_q.fsm            <= ST_IDLE;
      r_q.timeout_flag   <= `CCDO_FLAG_RESET;
      r_q.powerdown_flag <= `CCDO_FLAG_RESET;
    end else if (ce) begin
      r_q <= r_d;
    end
  end

  // bus outputs straight from the state register
  assign s_axi_awready = r_q.awready;
  assign s_axi_wready  = r_q.wready;
  assign s_axi_bvalid  = r_q.bvalid;
  assign s_axi_bresp   = r_q.bresp;
  assign s_axi_arready = r_q.arready;
  assign s_axi_rvalid  = r_q.rvalid;
  assign s_axi_rdata   = r_q.rdata;
  assign s_axi_rresp   = r_q.rresp;

  // watchdog clear zeroes counter and prescaler
  a_wdog_clear_cnt: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE1]
    (ce && exec && op == `CCDO_OP_WDCLR) |=> (r_q.wdog_cnt == 8'h00 && r_q.wdog_pre == 8'h00))
    else $error("watchdog not cleared");

  // watchdog clear raises both status flags
  a_wdog_flags_set: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE2]
    (ce && exec && op == `CCDO_OP_WDCLR) |=> (r_q.timeout_flag && r_q.powerdown_flag))
    else $error("timeout or powerdown flag not set");

  // call via W pushes the return address
  a_call_via_working_reg_push: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE3]
    (ce && exec && op == `CCDO_OP_CALL_VIA_WORKING_REG) |=>
      (r_q.stack[r_q.sp] == $past(r_q.pc) + 15'h0001 && r_q.sp == $past(r_q.sp) + 4'h1))
    else $error("return address not pushed");

  // call via W loads PC from latch and W
  a_call_via_working_reg_target: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE4]
    (ce && exec && op == `CCDO_OP_CALL_VIA_WORKING_REG) |=> (r_q.pc == {$past(r_q.pclatch), $past(r_q.w)}))
    else $error("call target wrong");

  // call via W lasts two cycles and keeps the zero flag
  a_call_via_working_reg_two_cyc: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE5]
    (ce && exec && op == `CCDO_OP_CALL_VIA_WORKING_REG) |=>
      (r_q.fsm == ST_SECOND && r_q.zero == $past(r_q.zero)))
    else $error("call not two cycles or flag changed");

  // complement into W
  a_complement_file_instr_to_w: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE6]
    (ce && exec && op == `CCDO_OP_COMPLEMENT_FILE_INSTR && !dest) |=>
      (r_q.w == ~$past(fval) && r_q.zero == ($past(fval) == 8'hFF)))
    else $error("complement result wrong");

  // clear file zeroes the selected register and sets zero
  a_clear_file_instr_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE7]
    (ce && exec && op == `CCDO_OP_CLEAR_FILE_INSTR) |=> (r_q.file[$past(fsel)] == 8'h00 && r_q.zero))
    else $error("file clear wrong");

  // decrement into W with zero flag
  a_decrement_file_instr_to_w: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE8]
    (ce && exec && op == `CCDO_OP_DECREMENT_FILE_INSTR && !dest) |=>
      (r_q.w == $past(fval) - 8'h01 && r_q.zero == ($past(fval) == 8'h01)))
    else $error("decrement result wrong");

  // clear W
  a_clear_working_instr_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE9]
    (ce && exec && op == `CCDO_OP_CLEAR_WORKING_INSTR) |=> (r_q.w == 8'h00 && r_q.zero))
    else $error("working clear wrong");

  // decrement-skip back to file leaves flags alone
  a_decskz_store: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE10]
    (ce && exec && op == `CCDO_OP_DECSKZ && dest) |=>
      (r_q.file[$past(fsel)] == $past(fval) - 8'h01 && r_q.zero == $past(r_q.zero)))
    else $error("decrement-skip store wrong");

  // zero result skips: PC advances by two over a second cycle
  a_decskz_skip: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE11]
    (ce && exec && op == `CCDO_OP_DECSKZ) |=>
      (($past(fval) == 8'h01) ? (r_q.fsm == ST_SECOND && r_q.pc == $past(r_q.pc) + 15'h0002)
                              : (r_q.fsm == ST_IDLE && r_q.pc == $past(r_q.pc) + 15'h0001)))
    else $error("skip handling wrong");

endmodule : ccdo_core

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the clear/call/decrement execution block
// Assumes: AXI4-Lite driven by non-blocking assignment at the rising edge; ce low once only
// Notes:   expected values are worked out here from the operation rules
`timescale 1ns/10ps
`include "ccdo_consts.svh"
module testbench;
  import ccdo_pkg::*;

  logic        aclk;
  logic        aresetn;
  logic        ce;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  int          fail_count;
  int          cmp_count;
  logic [31:0] d;
  logic [1:0]  r;
  logic [7:0]  pre0;

  ccdo_core u_ccdo_core (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // verdict and end of run
  task automatic summarize;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  // compare one value, report at once on mismatch
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  // a wait ran out: count it and close
  task automatic hang(input string name);
    fail_count++;
    $display("mismatch %s expected handshake seen timeout", name);
    summarize();
  endtask : hang

  // one write: address and data offered together, each released when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit aw_done;
    bit w_done;
    bit b_done;
    int n;
    aw_done = 0;
    w_done  = 0;
    b_done  = 0;
    n       = 0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= v;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!b_done && n < 100) begin
      @(posedge aclk);
      n++;
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
      if (aw_done && w_done && bvalid === 1'b1) begin
        b_done = 1;
        bready <= 1'b0;
        rs     = bresp;
      end
    end
    if (!b_done) hang("write");
  endtask : axi_write

  // one read: address held until taken, rready held until data seen
  task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    bit ar_done;
    bit r_done;
    int n;
    ar_done = 0;
    r_done  = 0;
    n       = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!r_done && n < 100) begin
      @(posedge aclk);
      n++;
      if (!ar_done && arready === 1'b1) begin
        ar_done = 1;
        arvalid <= 1'b0;
      end
      if (ar_done && rvalid === 1'b1) begin
        r_done = 1;
        rready <= 1'b0;
        v      = rdata;
        rs     = rresp;
      end
    end
    if (!r_done) hang("read");
  endtask : axi_read

  // register write expecting an OKAY answer
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [1:0] rs;
    axi_write(a, v, rs);
    check("bresp", {30'h0, `CCDO_RESP_OKAY}, {30'h0, rs});
  endtask : wr

  // register read compared with an expected word
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0]  rs;
    axi_read(a, v, rs);
    check(name, exp, v);
  endtask : rd_chk

  // load one file register through the address/data window
  task automatic setf(input logic [6:0] f, input logic [7:0] v);
    wr(`CCDO_ADDR_FADDR, {25'h0, f});
    wr(`CCDO_ADDR_FDATA, {24'h0, v});
  endtask : setf

  // read one file register back through the window
  task automatic chkf(input logic [6:0] f, input logic [7:0] exp);
    wr(`CCDO_ADDR_FADDR, {25'h0, f});
    rd_chk("file", `CCDO_ADDR_FDATA, {24'h0, exp});
  endtask : chkf

  // issue one operation and wait while busy
  task automatic exec(input logic [3:0] op, input logic dst, input logic [6:0] f);
    logic [31:0] v;
    logic [1:0]  rs;
    int n;
    n = 0;
    wr(`CCDO_ADDR_INSTR, {16'h0, 1'b0, f, dst, 3'h0, op});
    v = 32'h8;
    while (v[`CCDO_ST_BUSY] !== 1'b0 && n < 20) begin
      axi_read(`CCDO_ADDR_STATUS, v, rs);
      n++;
    end
    if (v[`CCDO_ST_BUSY] !== 1'b0) hang("busy");
  endtask : exec

  // main sequence
  initial begin
    fail_count = 0;
    cmp_count  = 0;
    aresetn = 1'b0;
    ce      = 1'b1;
    awaddr  = 8'h00;
    awvalid = 1'b0;
    wdata   = 32'h0;
    wstrb   = 4'h0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    araddr  = 8'h00;
    arvalid = 1'b0;
    rready  = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // reset state: flags timeout and powerdown high, zero low
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h6);
    rd_chk("wreg", `CCDO_ADDR_WREG, 32'h0);
    // watchdog runs, then clear zeroes counter and prescaler
    repeat (600) @(posedge aclk);
    axi_read(`CCDO_ADDR_WDOG, d, r);
    check("wdog_run", 32'h1, {31'h0, d[7:0] != 8'h00});
    // a full counter wrap drops the timeout flag, so the clear below has work to do
    repeat (65536) @(posedge aclk);
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h2);
    exec(`CCDO_OP_WDCLR, 1'b0, 7'h00);
    axi_read(`CCDO_ADDR_WDOG, d, r);
    check("wdog_cnt", 32'h0, {24'h0, d[7:0]});
    check("wdog_pre", 32'h1, {31'h0, d[15:8] < 8'h40});
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h6);
    // complement to W, then back to file with zero result
    setf(7'h05, 8'h5A);
    exec(`CCDO_OP_COMPLEMENT_FILE_INSTR, 1'b0, 7'h05);
    rd_chk("wreg", `CCDO_ADDR_WREG, 32'hA5);
    chkf(7'h05, 8'h5A);
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h6);
    setf(7'h05, 8'hFF);
    exec(`CCDO_OP_COMPLEMENT_FILE_INSTR, 1'b1, 7'h05);
    chkf(7'h05, 8'h00);
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h7);
    // decrement to zero in file, then wrap to W
    setf(7'h06, 8'h01);
    exec(`CCDO_OP_DECREMENT_FILE_INSTR, 1'b1, 7'h06);
    chkf(7'h06, 8'h00);
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h7);
    exec(`CCDO_OP_DECREMENT_FILE_INSTR, 1'b0, 7'h06);
    rd_chk("wreg", `CCDO_ADDR_WREG, 32'hFF);
    chkf(7'h06, 8'h00);
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h6);
    // clear the highest file register
    setf(7'h7F, 8'h33);
    exec(`CCDO_OP_CLEAR_FILE_INSTR, 1'b0, 7'h7F);
    chkf(7'h7F, 8'h00);
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h7);
    // clear W from a nonzero value with zero flag low
    wr(`CCDO_ADDR_WREG, 32'h77);
    wr(`CCDO_ADDR_STATUS, 32'h0);
    exec(`CCDO_OP_CLEAR_WORKING_INSTR, 1'b0, 7'h00);
    rd_chk("wreg", `CCDO_ADDR_WREG, 32'h0);
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h7);
    // call via W: push return address, jump to latch and W, flags kept
    wr(`CCDO_ADDR_WREG, 32'h34);
    wr(`CCDO_ADDR_PCLATCH, 32'h55);
    wr(`CCDO_ADDR_PC, 32'h0123);
    exec(`CCDO_OP_CALL_VIA_WORKING_REG, 1'b0, 7'h00);
    rd_chk("tos", `CCDO_ADDR_TOS, 32'h00010124);
    rd_chk("pc", `CCDO_ADDR_PC, 32'h5534);
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h7);
    // decrement-skip reaching zero: skip taken, zero flag untouched
    wr(`CCDO_ADDR_PC, 32'h0100);
    setf(7'h09, 8'h01);
    wr(`CCDO_ADDR_STATUS, 32'h0);
    exec(`CCDO_OP_DECSKZ, 1'b1, 7'h09);
    chkf(7'h09, 8'h00);
    rd_chk("pc", `CCDO_ADDR_PC, 32'h0102);
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h16);
    // decrement-skip nonzero into W: no skip, zero flag untouched
    wr(`CCDO_ADDR_PC, 32'h0200);
    setf(7'h09, 8'h02);
    wr(`CCDO_ADDR_STATUS, 32'h1);
    exec(`CCDO_OP_DECSKZ, 1'b0, 7'h09);
    rd_chk("wreg", `CCDO_ADDR_WREG, 32'h01);
    chkf(7'h09, 8'h02);
    rd_chk("pc", `CCDO_ADDR_PC, 32'h0201);
    rd_chk("status", `CCDO_ADDR_STATUS, 32'h7);
    // unmapped read and write are refused
    axi_read(8'h40, d, r);
    check("rresp", {30'h0, `CCDO_RESP_SLVERR}, {30'h0, r});
    check("rdata", 32'h0, d);
    axi_write(8'h44, 32'hFFFF_FFFF, r);
    check("bresp", {30'h0, `CCDO_RESP_SLVERR}, {30'h0, r});
    // no-operation only advances the program counter
    exec(`CCDO_OP_NOP, 1'b0, 7'h00);
    rd_chk("pc", `CCDO_ADDR_PC, 32'h0202);
    // ce low freezes the watchdog prescaler
    axi_read(`CCDO_ADDR_WDOG, d, r);
    pre0 = d[15:8];
    ce <= 1'b0;
    repeat (50) @(posedge aclk);
    ce <= 1'b1;
    axi_read(`CCDO_ADDR_WDOG, d, r);
    check("wdog_frozen", 32'h1, {31'h0, (d[15:8] - pre0) < 8'h10});
    summarize();
  end

endmodule : testbench
